// ### hdl/dsc_pkg.sv
// constants, register layout and types for the clock speed select block
// Operation
// - a machine cycle lasts 6 input clock periods in double speed and 12 in standard speed.
// - standard speed halves the crystal clock for core and peripherals; double speed bypasses it for the core and for peripherals whose select is clear.
// - bit 0 of the clock control register set selects double speed for the cpu and for peripherals whose select is clear, clear returns.
// - after any reset the block runs at standard speed unless the boot fast-start fuse is set.
// - with the boot fast-start fuse set, the block leaves reset requesting double speed and enters it at the first rise of the halved clock.
// - a change of the double speed request takes effect only on a rising edge of the halved clock.
// - each peripheral runs doubled only when the cpu runs at double speed (bit 0 or boot fuse) and its select is clear.
// - with the cpu at double speed, a peripheral select at zero gives 6 periods per peripheral cycle, at one gives 12.
// - the clock control register at 8Fh holds seven peripheral selects in bits 7..1, cpu bit 0.
// - every reset clears the clock control register to zero.
// - the device is held in reset while its reset pin is high, for cold and warm restart.
// - a warm reset may also come from internal sources such as watchdog, counter array or timer.
// - a watchdog reset drives a pulse of 96 clock periods onto the reset pin.
package dsc_pkg;

  // register map
  localparam logic [7:0] DSC_CLOCK_SPEED_CONTROL_ADDR = 8'h8F;
  localparam logic [7:0] DSC_CLOCK_SPEED_CONTROL_RESET = 8'h00;
  localparam int DSC_CPU_BIT = 0;
  localparam int DSC_NUM_PERIPH = 7;

  // timing, in input clock periods; the clock period itself in picoseconds
  localparam int DSC_CLK_PERIOD_PS = 4000;
  localparam int DSC_STD_PERIODS_PER_MCYCLE = 12;
  localparam int DSC_X2_PERIODS_PER_MCYCLE = 6;
  localparam int DSC_TICKS_PER_MCYCLE = DSC_X2_PERIODS_PER_MCYCLE;
  localparam int DSC_WARM_RESET_MIN_PERIODS = 24;
  localparam int DSC_WD_PULSE_PERIODS = 96;
  // mclk is the crystal input, so one period is one cycle
  localparam int DSC_WD_PULSE_CYCLES = (DSC_WD_PULSE_PERIODS * DSC_CLK_PERIOD_PS
                                        + DSC_CLK_PERIOD_PS - 1) / DSC_CLK_PERIOD_PS;

  // internal reset source indices
  localparam int DSC_SRC_WATCHDOG = 0;
  localparam int DSC_SRC_COUNTER_ARRAY = 1;
  localparam int DSC_SRC_TIMER = 2;
  localparam int DSC_NUM_RST_SRC = 3;

  // clock control register, bit 7 down to bit 0
  typedef struct packed {
    logic can_unit_speed_sel;
    logic watchdog_speed_sel;
    logic counter_array_speed_sel;
    logic serial_port_speed_sel;
    logic timer2_speed_sel;
    logic timer1_speed_sel;
    logic timer0_speed_sel;
    logic cpu_double_speed;
  } dsc_clock_speed_control_type;

  // register port bundle
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dsc_sfr_req_type;

  typedef enum logic [1:0] {
    DSC_WD_IDLE = 2'b01,
    DSC_WD_PULSE = 2'b10
  } dsc_wd_state_type;

endpackage

// ### hdl/dsc_double_speed_clock_select.sv
// clock speed select, halving stage bypass and reset entry
`timescale 1ns/1ps
module dsc_double_speed_clock_select
(
  // clock and system reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input dsc_pkg::dsc_sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata,
  // straps and reset sources
  input wire logic boot_fast_start_fuse,
  input wire logic [dsc_pkg::DSC_NUM_RST_SRC-1:0] int_reset_req,
  // reset pin, two-way
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  // clocking to core and peripherals
  output logic crystal_half_clk,
  output logic cpu_double_speed_active,
  output logic cpu_clk_en,
  output logic machine_cycle,
  output logic [dsc_pkg::DSC_NUM_PERIPH-1:0] periph_clk_en,
  output logic [dsc_pkg::DSC_NUM_PERIPH-1:0] periph_cycle,
  output logic core_reset
);
  import dsc_pkg::*;

  logic any_rst;
  dsc_clock_speed_control_type clock_speed_control_q;
  logic boot_fast_q;
  logic x2_req;
  logic div2_q;
  logic x2_active_q;
  logic cpu_en_q;
  logic [2:0] cpu_tick_q;
  logic mcycle_q;
  logic [DSC_NUM_PERIPH-1:0] per_en_q;
  logic [DSC_NUM_PERIPH-1:0] per_cyc_q;
  logic [7:0] rdata_q;
  logic core_reset_q;
  dsc_wd_state_type wd_state_q;
  logic [6:0] wd_cnt_q;
  logic wd_oe_q;

  // pin, internal sources and system reset all restart the block, except the halving stage, the watchdog pulse and the read data, which take system reset only
  assign any_rst = reset | rst_pin_in | (|int_reset_req);

  always_ff @(posedge mclk)
  begin
    core_reset_q <= any_rst;
  end

  // clock control register
  always_ff @(posedge mclk)
  begin
    if (any_rst)
    begin
      clock_speed_control_q <= dsc_clock_speed_control_type'(DSC_CLOCK_SPEED_CONTROL_RESET);
    end
    else if (sfr_req.wr && sfr_req.addr == DSC_CLOCK_SPEED_CONTROL_ADDR)
    begin
      clock_speed_control_q <= dsc_clock_speed_control_type'(sfr_req.wdata);
    end
  end

  // fuse caught while reset is held; any write to the register hands control to software
  always_ff @(posedge mclk)
  begin
    if (any_rst)
    begin
      boot_fast_q <= boot_fast_start_fuse;
    end
    else if (sfr_req.wr && sfr_req.addr == DSC_CLOCK_SPEED_CONTROL_ADDR)
    begin
      boot_fast_q <= 1'b0;
    end
  end

  assign x2_req = clock_speed_control_q.cpu_double_speed | boot_fast_q;

  always_ff @(posedge mclk)
  begin
    if (!reset && sfr_req.rd && sfr_req.addr == DSC_CLOCK_SPEED_CONTROL_ADDR)
    begin
      rdata_q <= clock_speed_control_q;
    end
    else
    begin
      rdata_q <= 8'h00;
    end
  end

  // halving stage; it runs through pin and internal resets, only system reset holds it
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      div2_q <= 1'b0;
    end
    else
    begin
      div2_q <= ~div2_q;
    end
  end

  // mode flop moves only as the halved clock rises, avoiding a short phase
  always_ff @(posedge mclk)
  begin
    if (any_rst)
    begin
      x2_active_q <= 1'b0;
    end
    else if (!div2_q)
    begin
      x2_active_q <= x2_req;
    end
  end

  // cpu enable: every period doubled, every other period otherwise
  always_ff @(posedge mclk)
  begin
    if (any_rst)
    begin
      cpu_en_q <= 1'b0;
    end
    else
    begin
      cpu_en_q <= x2_active_q | ~div2_q;
    end
  end

  // six core ticks make one machine cycle
  always_ff @(posedge mclk)
  begin
    if (any_rst)
    begin
      cpu_tick_q <= 3'h0;
      mcycle_q <= 1'b0;
    end
    else
    begin
      mcycle_q <= cpu_en_q && cpu_tick_q == 3'(DSC_TICKS_PER_MCYCLE - 1);
      if (cpu_en_q)
      begin
        if (cpu_tick_q == 3'(DSC_TICKS_PER_MCYCLE - 1))
        begin
          cpu_tick_q <= 3'h0;
        end
        else
        begin
          cpu_tick_q <= cpu_tick_q + 3'h1;
        end
      end
    end
  end

  // per peripheral enable and cycle strobe
  genvar gi;
  generate
    for (gi = 0; gi < DSC_NUM_PERIPH; gi++)
    begin : g_per
      logic fast;
      logic [2:0] tick_q;
      // select bit is ignored while the cpu runs at standard speed
      assign fast = x2_active_q & ~clock_speed_control_q[gi + 1];

      always_ff @(posedge mclk)
      begin
        if (any_rst)
        begin
          per_en_q[gi] <= 1'b0;
          per_cyc_q[gi] <= 1'b0;
          tick_q <= 3'h0;
        end
        else
        begin
          per_en_q[gi] <= fast | ~div2_q;
          per_cyc_q[gi] <= per_en_q[gi] && tick_q == 3'(DSC_TICKS_PER_MCYCLE - 1);
          if (per_en_q[gi])
          begin
            if (tick_q == 3'(DSC_TICKS_PER_MCYCLE - 1))
            begin
              tick_q <= 3'h0;
            end
            else
            begin
              tick_q <= tick_q + 3'h1;
            end
          end
        end
      end
    end
  endgenerate

  // watchdog pulse on the pin; only system reset stops it, since the pulse feeds back on the pin
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wd_state_q <= DSC_WD_IDLE;
      wd_cnt_q <= 7'h00;
      wd_oe_q <= 1'b0;
    end
    else
    begin
      case (wd_state_q)
        DSC_WD_IDLE:
        begin
          if (int_reset_req[DSC_SRC_WATCHDOG])
          begin
            wd_state_q <= DSC_WD_PULSE;
            wd_cnt_q <= 7'h00;
            wd_oe_q <= 1'b1;
          end
        end
        DSC_WD_PULSE:
        begin
          wd_cnt_q <= wd_cnt_q + 7'h01;
          if (wd_cnt_q == 7'(DSC_WD_PULSE_CYCLES - 1))
          begin
            wd_state_q <= DSC_WD_IDLE;
            wd_oe_q <= 1'b0;
          end
        end
        default:
        begin
          wd_state_q <= DSC_WD_IDLE;
          wd_oe_q <= 1'b0;
        end
      endcase
    end
  end

  assign sfr_rdata = rdata_q;
  assign rst_pin_out = wd_oe_q;
  assign rst_pin_oe = wd_oe_q;
  assign crystal_half_clk = div2_q;
  assign cpu_double_speed_active = x2_active_q;
  assign cpu_clk_en = cpu_en_q;
  assign machine_cycle = mcycle_q;
  assign periph_clk_en = per_en_q;
  assign periph_cycle = per_cyc_q;
  assign core_reset = core_reset_q;

  // checks
  logic [7:0] ast_len_q;
  always_ff @(posedge mclk)
  begin
    if (reset || !wd_oe_q)
    begin
      ast_len_q <= 8'h00;
    end
    else
    begin
      ast_len_q <= ast_len_q + 8'h01;
    end
  end

  sequence s_x2_mcycle_start;
    mcycle_q && cpu_en_q ##0 x2_active_q [*5];
  endsequence

  AST_RESET_CLEARS: assert property (@(posedge mclk) any_rst |=> clock_speed_control_q == 8'h00)
    else $error("clock control not cleared by reset");
  AST_CORE_RESET: assert property (@(posedge mclk) any_rst |=> core_reset_q)
    else $error("core reset not raised");
  AST_X2_ON_RISE: assert property (@(posedge mclk) disable iff (any_rst)
    !$past(any_rst) && $changed(x2_active_q) |-> div2_q)
    else $error("mode changed off the halved clock rise");
  AST_STD_HALF: assert property (@(posedge mclk) disable iff (any_rst)
    !x2_active_q && cpu_en_q |=> !cpu_en_q)
    else $error("standard speed enable not halved");
  AST_X2_BYPASS: assert property (@(posedge mclk) disable iff (any_rst)
    !$past(any_rst) && x2_active_q && $past(x2_active_q) |-> cpu_en_q)
    else $error("double speed enable not continuous");
  AST_MCYCLE_MIN: assert property (@(posedge mclk) disable iff (any_rst)
    mcycle_q |=> !mcycle_q [*5])
    else $error("machine cycle shorter than six periods");
  AST_MCYCLE_X2: assert property (@(posedge mclk) disable iff (any_rst)
    s_x2_mcycle_start |-> ##2 mcycle_q)
    else $error("double speed machine cycle not six periods");
  AST_PER_SLOW: assert property (@(posedge mclk) disable iff (any_rst)
    !$past(any_rst) && clock_speed_control_q.timer0_speed_sel && $past(clock_speed_control_q.timer0_speed_sel)
    && periph_clk_en[0] |=> !periph_clk_en[0])
    else $error("selected peripheral not at standard speed");
  AST_PER_FAST: assert property (@(posedge mclk) disable iff (any_rst)
    !$past(any_rst) && $past(x2_active_q) && !$past(clock_speed_control_q.can_unit_speed_sel)
    |-> periph_clk_en[6])
    else $error("peripheral not doubled with select clear");
  AST_BOOT_X2: assert property (@(posedge mclk)
    $fell(any_rst) && $past(boot_fast_start_fuse) |-> x2_req)
    else $error("boot fuse did not request double speed");
  AST_WD_PULSE: assert property (@(posedge mclk) disable iff (reset)
    $fell(wd_oe_q) |-> ast_len_q == 8'(DSC_WD_PULSE_CYCLES))
    else $error("watchdog pin pulse not 96 periods");
  AST_WRITE: assert property (@(posedge mclk) disable iff (any_rst)
    sfr_req.wr && sfr_req.addr == DSC_CLOCK_SPEED_CONTROL_ADDR ##1 !any_rst
    |-> clock_speed_control_q == $past(sfr_req.wdata))
    else $error("register write not stored");

endmodule

// ### dv/dsc_board_model.sv
// board model: reset pin loop with pull-down and a reset switch
`timescale 1ns/1ps
module dsc_board_model
(
  // clock
  input wire logic mclk,
  // reset pin, two-way
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  output logic rst_pin_in,
  // switch
  input wire logic push_reset
);
  logic [4:0] hold_q = 5'h00;
  // a press is stretched to the minimum warm hold of 24 periods
  always_ff @(posedge mclk)
  begin
    if (push_reset)
      hold_q <= 5'h18;
    else if (hold_q != 5'h00)
      hold_q <= hold_q - 5'h01;
  end
  // pull-down: a released pin reads low, never the last driven level
  assign rst_pin_in = (rst_pin_oe & rst_pin_out) | (hold_q != 5'h00);
endmodule

// ### dv/testbench.sv
// self-checking bench for the clock speed select block
`timescale 1ns/1ps
module testbench;
  import dsc_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  dsc_sfr_req_type sfr_req = '0;
  logic boot_fast_start_fuse = 1'b0;
  logic push_reset = 1'b0;
  logic [DSC_NUM_RST_SRC-1:0] int_reset_req = '0;
  logic [7:0] sfr_rdata, tap, rd_v;
  logic rst_pin_in, rst_pin_out, rst_pin_oe, crystal_half_clk, cpu_double_speed_active;
  logic cpu_clk_en, machine_cycle, core_reset, e;
  logic [DSC_NUM_PERIPH-1:0] periph_clk_en, periph_cycle;
  logic [7:0] pats [4] = '{8'h01, 8'h55, 8'hAB, 8'hFE};
  logic [6:0] fast_exp;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int gap, k;
  assign tap = {periph_cycle, machine_cycle};
  always #2 mclk = ~mclk;
  dsc_double_speed_clock_select u_dsc_double_speed_clock_select
  (
    .mclk(mclk), .reset(reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .boot_fast_start_fuse(boot_fast_start_fuse), .int_reset_req(int_reset_req),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .crystal_half_clk(crystal_half_clk), .cpu_double_speed_active(cpu_double_speed_active),
    .cpu_clk_en(cpu_clk_en), .machine_cycle(machine_cycle), .periph_clk_en(periph_clk_en),
    .periph_cycle(periph_cycle), .core_reset(core_reset)
  );
  dsc_board_model u_dsc_board_model
  (
    .mclk(mclk), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .rst_pin_in(rst_pin_in), .push_reset(push_reset)
  );
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge mclk);
    sfr_req.wr = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge mclk);
    sfr_req.rd = 1'b0;
    d = sfr_rdata;
  endtask
  // gap between two pulses of one tap bit, bounded so a dead tap cannot hang
  task automatic measure(input int b, output int n);
    int w;
    w = 0;
    n = 1;
    while (tap[b] !== 1'b1 && w < 40)
    begin
      @(negedge mclk);
      w++;
    end
    @(negedge mclk);
    while (tap[b] !== 1'b1 && n < 40)
    begin
      @(negedge mclk);
      n++;
    end
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      num_errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    reg_rd(8'h8F, rd_v);
    check("clock_speed_control rst", rd_v, 8'h00);
    check("x2 rst", cpu_double_speed_active, 1'b0);
    e = cpu_clk_en;
    @(negedge mclk);
    check("std en", cpu_clk_en, !e);
    reg_wr(8'h8F, 8'h01);
    k = 0;
    while (cpu_double_speed_active !== 1'b1 && k < 8)
    begin
      @(negedge mclk);
      k++;
    end
    check("switch edge", crystal_half_clk, 1'b1);
    repeat (3) @(negedge mclk);
    check("x2 en", cpu_clk_en, 1'b1);
    // each mode gets time to settle before gaps are taken
    for (int p = 0; p < 4; p++)
    begin
      reg_wr(8'h8F, pats[p]);
      reg_rd(8'h8F, rd_v);
      check("clock_speed_control rb", rd_v, pats[p]);
      repeat (30) @(negedge mclk);
      for (int b = 0; b < 8; b++)
      begin
        measure(b, gap);
        check("gap", gap, (pats[p][0] && !(b > 0 && pats[p][b])) ? 6 : 12);
      end
      fast_exp = pats[p][0] ? (pats[p][7:1] ^ 7'h7F) : 7'h00;
      check("per en", periph_clk_en & (pats[p][7:1] ^ 7'h7F), fast_exp);
    end
    check("x2 off", cpu_double_speed_active, 1'b0);
    reg_wr(8'h8E, 8'hFF);
    reg_rd(8'h8E, rd_v);
    check("unmapped", rd_v, 8'h00);
    reg_rd(8'h8F, rd_v);
    check("clock_speed_control kept", rd_v, 8'hFE);
    for (int i = 1; i < 3; i++)
    begin
      reg_wr(8'h8F, 8'hFF);
      int_reset_req[i] = 1'b1;
      repeat (2) @(negedge mclk);
      check("int rst", core_reset, 1'b1);
      int_reset_req[i] = 1'b0;
      repeat (3) @(negedge mclk);
      reg_rd(8'h8F, rd_v);
      check("clock_speed_control clr", rd_v, 8'h00);
    end
    int_reset_req[0] = 1'b1;
    @(negedge mclk);
    int_reset_req[0] = 1'b0;
    check("wd out", rst_pin_out, 1'b1);
    k = 0;
    while (rst_pin_oe === 1'b1 && k < 200)
    begin
      @(negedge mclk);
      k++;
    end
    check("wd pulse", k, 96);
    push_reset = 1'b1;
    @(negedge mclk);
    push_reset = 1'b0;
    repeat (2) @(negedge mclk);
    check("pin rst", core_reset, 1'b1);
    repeat (30) @(negedge mclk);
    check("pin free", core_reset, 1'b0);
    boot_fast_start_fuse = 1'b1;
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    check("boot x2", cpu_double_speed_active, 1'b1);
    reg_rd(8'h8F, rd_v);
    check("boot clock_speed_control", rd_v, 8'h00);
    measure(0, gap);
    check("boot gap", gap, 6);
    summarize();
  end
endmodule
